// >>> common/ccp_defines.svh
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// Register byte offsets on the bus.
`define OFS_CV1_LOW     5'h00
`define OFS_CV1_HIGH    5'h04
`define OFS_UNIT1_CTRL  5'h08
`define OFS_CV2_LOW     5'h0C
`define OFS_CV2_HIGH    5'h10
`define OFS_UNIT2_CTRL  5'h14
`define OFS_TIMER_SEL   5'h18
`define OFS_FLAGS       5'h1C

// Control register fields.
`define CTRL_MODE_MSB   3
`define CTRL_DUTY_LSB   4
`define CTRL_DUTY_MSB   5
`define CTRL_RESET      6'h00
`define CV_RESET        16'h0000
`define SEL_RESET       2'h0

// Mode codes.
`define MODE_OFF        4'h0
`define MODE_TOGGLE     4'h2
`define MODE_SET_HIGH   4'h8
`define MODE_SET_LOW    4'h9
`define MODE_SOFT_INT   4'hA
`define MODE_SPECIAL    4'hB
`define MODE_PWM_TOP    2'h3

// Flags register fields.
`define FLAG_UNIT1      0
`define FLAG_UNIT2      1
`define FLAG_LATCH1     2
`define FLAG_LATCH2     3

`endif

// >>> common/ccp_pkg.sv
package ccp_pkg;

	typedef enum logic {
		BUS_DONE = 1'b0,
		BUS_WAIT = 1'b1
	} bus_state_t;

	typedef struct packed {
		logic eq_prev;
		logic out_latch;
	} chan_state_t;

	typedef struct packed {
		logic [9:0] duty;
		logic       out;
	} pwm_state_t;

	typedef struct packed {
		bus_state_t  bus;
		logic [31:0] rdata;
		logic [15:0] cv1;
		logic [5:0]  ctrl1;
		logic [15:0] cv2;
		logic [5:0]  ctrl2;
		logic [1:0]  tsel;
		logic        flag1;
		logic        flag2;
		logic        pin1;
		logic        oe1_n;
		logic        pin2;
		logic        oe2_n;
		logic        t1_clear;
		logic        t3_clear;
		logic        suppress;
		logic        adc;
	} top_state_t;

endpackage

// >>> hw/ccp_compare_channel.sv
`include "ccp_defines.svh"

module ccp_compare_channel
	import ccp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] compare_value,
	input  wire logic [15:0] timer_one_count,
	input  wire logic [15:0] timer_three_count,
	input  wire logic        use_timer_three,
	input  wire logic [3:0]  mode,
	input  wire logic        ctrl_wr,
	input  wire logic [3:0]  ctrl_mode,
	output logic             match_hit,
	output logic             trigger_hit,
	output logic             out_latch
);

	chan_state_t s_q;
	chan_state_t s_d;
	logic        eq;
	logic        compare_mode;

	always_comb begin
		eq = compare_value == (use_timer_three ? timer_three_count : timer_one_count); // RULE1
		compare_mode = (mode == `MODE_TOGGLE) || (mode == `MODE_SET_HIGH) || // RULE15
			(mode == `MODE_SET_LOW) || (mode == `MODE_SOFT_INT) || (mode == `MODE_SPECIAL);
		// Only the first cycle of equality counts, so a stalled timer acts once.
		match_hit = compare_mode && eq && !s_q.eq_prev && !ctrl_wr; // RULE18
		trigger_hit = match_hit && (mode == `MODE_SPECIAL);
		s_d = s_q;
		s_d.eq_prev = compare_mode && eq;
		if (ctrl_wr) begin
			case (ctrl_mode)
				`MODE_OFF: begin
					s_d = '0; // RULE4 RULE16
				end
				`MODE_SET_HIGH: s_d.out_latch = 1'b0; // RULE15
				`MODE_SET_LOW: s_d.out_latch = 1'b1; // RULE15
				default: s_d.out_latch = s_q.out_latch;
			endcase
		end else if (match_hit) begin
			case (mode) // RULE2
				`MODE_SET_HIGH: s_d.out_latch = 1'b1;
				`MODE_SET_LOW: s_d.out_latch = 1'b0;
				`MODE_TOGGLE: s_d.out_latch = !s_q.out_latch;
				default: s_d.out_latch = s_q.out_latch; // RULE7
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign out_latch = s_q.out_latch;

	a_toggle_on_match: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
		match_hit && mode == `MODE_TOGGLE |=> out_latch != $past(out_latch))
		else $error("Toggle match did not invert the latch.");

	a_single_match: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
		match_hit |=> !match_hit)
		else $error("Match pulse lasted more than one cycle.");

	a_zero_clears: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
		ctrl_wr && ctrl_mode == `MODE_OFF |=> !out_latch && !match_hit)
		else $error("Zero control write left the latch high.");

endmodule // ccp_compare_channel

// >>> hw/ccp_pwm_unit.sv
`include "ccp_defines.svh"

module ccp_pwm_unit
	import ccp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       enabled,
	input  wire logic       ctrl_zero,
	input  wire logic [9:0] duty_next,
	input  wire logic [7:0] timer_two_count,
	input  wire logic [1:0] timer_two_fine,
	input  wire logic       period_match,
	output logic            pwm_out
);

	pwm_state_t s_q;
	pwm_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (ctrl_zero || !enabled) begin
			s_d.out = 1'b0; // RULE14
		end else if (period_match) begin
			// The duty is double buffered so a mid-period write cannot glitch the pin.
			s_d.duty = duty_next; // RULE13
			s_d.out = duty_next != 10'h000;
		end else if ({timer_two_count, timer_two_fine} == s_q.duty) begin
			s_d.out = 1'b0; // RULE13
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pwm_out = s_q.out;

	a_pwm_zero_low: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14
		ctrl_zero |=> !pwm_out)
		else $error("Zero control write left the PWM latch high.");

endmodule // ccp_pwm_unit

// >>> hw/ccp_compare_top.sv
// Contract
// RULE1: In compare mode each unit compares its 16-bit value with its selected timer.
// RULE2: On match, drive pin high, low, toggle it, or leave it per mode.
// RULE3: The match flag is set together with the pin action; software clears it. The code sets the flag one cycle before the unit pin changes.
// RULE4: Writing zero to a unit control register forces its compare latch low.
// RULE5: Software runs the compare timer in timer or synchronized counter mode.
// RULE6: Software clears the port direction bit so the unit pin is an output.
// RULE7: Software interrupt mode leaves the pin alone and only sets the flag.
// RULE8: Unit 1 special event clears timer one, making it a 16-bit period.
// RULE9: Unit 2 special event clears whichever timer it is using.
// RULE10: Unit 2 special event starts an A/D conversion when the converter is enabled.
// RULE11: A timer cleared by unit 2's trigger does not set its own flag.
// RULE12: Software writes zero before a new mode when changing the capture prescaler.
// RULE13: Unit 1 PWM mode drives a pulse-width output with up to 10-bit duty.
// RULE14: Writing zero to unit 1 control forces the PWM latch low.
// RULE15: Modes 1000, 1001, 0010, 1010 and 1011 are the decoded compare modes.
// RULE16: Mode 0000 disables the unit and resets its internal state.
// RULE17: Timer one or three per unit comes from the timer select bits.
// RULE18: Trigger and flag set pulse once per match, not while equality lasts.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`include "ccp_defines.svh"

module ccp_compare_top
	import ccp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [15:0] timer_one_count,
	input  wire logic [15:0] timer_three_count,
	input  wire logic [7:0]  timer_two_count,
	input  wire logic [1:0]  timer_two_fine,
	input  wire logic        timer_two_period_match,
	input  wire logic        adc_enable,
	input  wire logic        port_c_direction_unit1,
	input  wire logic        port_c_direction_unit2,
	input  wire logic        port_data_unit1,
	input  wire logic        port_data_unit2,
	output logic             unit1_output_pin,
	output logic             unit1_output_pin_oe_n,
	output logic             unit2_output_pin,
	output logic             unit2_output_pin_oe_n,
	output logic             unit1_match_flag,
	output logic             unit2_match_flag,
	output logic             timer_one_clear,
	output logic             timer_three_clear,
	output logic             timer_flag_suppress,
	output logic             adc_start
);

	top_state_t  s_q;
	top_state_t  s_d;
	logic        wr_go;
	logic        ctrl1_wr;
	logic        ctrl2_wr;
	logic        ctrl1_zero;
	logic        flags_wr;
	logic [7:0]  wbyte;
	logic [3:0]  mode1;
	logic [3:0]  mode2;
	logic        match1;
	logic        match2;
	logic        trig1;
	logic        trig2;
	logic        latch1;
	logic        latch2;
	logic        pwm1;
	logic        pwm1_mode;
	logic [31:0] rd_value;

	assign mode1 = s_q.ctrl1[`CTRL_MODE_MSB:0];
	assign mode2 = s_q.ctrl2[`CTRL_MODE_MSB:0];
	assign pwm1_mode = mode1[3:2] == `MODE_PWM_TOP;
	assign wbyte = avs_writedata[7:0];
	// A write lands only at the edge where waitrequest is low, as the bus requires.
	assign wr_go = (s_q.bus == BUS_DONE) && avs_write && avs_byteenable[0];
	assign ctrl1_wr = wr_go && (avs_address == `OFS_UNIT1_CTRL);
	assign ctrl2_wr = wr_go && (avs_address == `OFS_UNIT2_CTRL);
	assign ctrl1_zero = ctrl1_wr && (wbyte == 8'h00);
	assign flags_wr = wr_go && (avs_address == `OFS_FLAGS);

	ccp_compare_channel u_chan1 (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.compare_value     (s_q.cv1),
		.timer_one_count   (timer_one_count),
		.timer_three_count (timer_three_count),
		.use_timer_three   (s_q.tsel[0]),
		.mode              (mode1),
		.ctrl_wr           (ctrl1_wr),
		.ctrl_mode         (wbyte[3:0]),
		.match_hit         (match1),
		.trigger_hit       (trig1),
		.out_latch         (latch1)
	);

	ccp_compare_channel u_chan2 (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.compare_value     (s_q.cv2),
		.timer_one_count   (timer_one_count),
		.timer_three_count (timer_three_count),
		.use_timer_three   (s_q.tsel[1]),
		.mode              (mode2),
		.ctrl_wr           (ctrl2_wr),
		.ctrl_mode         (wbyte[3:0]),
		.match_hit         (match2),
		.trigger_hit       (trig2),
		.out_latch         (latch2)
	);

	ccp_pwm_unit u_pwm1 (
		.core_clk        (core_clk),
		.arst_n          (arst_n),
		.enabled         (pwm1_mode),
		.ctrl_zero       (ctrl1_zero),
		.duty_next       ({s_q.cv1[7:0], s_q.ctrl1[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB]}),
		.timer_two_count (timer_two_count),
		.timer_two_fine  (timer_two_fine),
		.period_match    (timer_two_period_match),
		.pwm_out         (pwm1)
	);

	always_comb begin
		rd_value = 32'h0000_0000;
		if (avs_address == `OFS_CV1_LOW) begin
			rd_value[7:0] = s_q.cv1[7:0];
		end else if (avs_address == `OFS_CV1_HIGH) begin
			rd_value[7:0] = s_q.cv1[15:8];
		end else if (avs_address == `OFS_UNIT1_CTRL) begin
			rd_value[5:0] = s_q.ctrl1;
		end else if (avs_address == `OFS_CV2_LOW) begin
			rd_value[7:0] = s_q.cv2[7:0];
		end else if (avs_address == `OFS_CV2_HIGH) begin
			rd_value[7:0] = s_q.cv2[15:8];
		end else if (avs_address == `OFS_UNIT2_CTRL) begin
			rd_value[5:0] = s_q.ctrl2;
		end else if (avs_address == `OFS_TIMER_SEL) begin
			rd_value[1:0] = s_q.tsel;
		end else if (avs_address == `OFS_FLAGS) begin
			rd_value[`FLAG_UNIT1] = s_q.flag1;
			rd_value[`FLAG_UNIT2] = s_q.flag2;
			rd_value[`FLAG_LATCH1] = latch1;
			rd_value[`FLAG_LATCH2] = latch2;
		end
	end

	always_comb begin
		s_d = s_q;

		// Bus handshake: one wait cycle, then a single cycle with waitrequest low.
		case (s_q.bus)
			BUS_WAIT: begin
				if (avs_read || avs_write) begin
					s_d.bus = BUS_DONE;
					s_d.rdata = rd_value;
				end
			end
			BUS_DONE: begin
				s_d.bus = BUS_WAIT;
			end
			default: begin
				s_d.bus = BUS_WAIT;
			end
		endcase

		if (wr_go) begin
			if (avs_address == `OFS_CV1_LOW) begin
				s_d.cv1[7:0] = wbyte;
			end else if (avs_address == `OFS_CV1_HIGH) begin
				s_d.cv1[15:8] = wbyte;
			end else if (avs_address == `OFS_UNIT1_CTRL) begin
				s_d.ctrl1 = wbyte[5:0];
			end else if (avs_address == `OFS_CV2_LOW) begin
				s_d.cv2[7:0] = wbyte;
			end else if (avs_address == `OFS_CV2_HIGH) begin
				s_d.cv2[15:8] = wbyte;
			end else if (avs_address == `OFS_UNIT2_CTRL) begin
				s_d.ctrl2 = wbyte[5:0];
			end else if (avs_address == `OFS_TIMER_SEL) begin
				s_d.tsel = wbyte[1:0]; // RULE17
			end
		end

		// A match in the clearing cycle keeps its flag: set wins over clear.
		s_d.flag1 = match1 || (s_q.flag1 && !(flags_wr && wbyte[`FLAG_UNIT1])); // RULE3
		s_d.flag2 = match2 || (s_q.flag2 && !(flags_wr && wbyte[`FLAG_UNIT2])); // RULE3

		// Unit 1 always clears timer one; unit 2 clears the timer it compares against.
		s_d.t1_clear = trig1 || (trig2 && !s_q.tsel[1]); // RULE8 RULE9
		s_d.t3_clear = trig2 && s_q.tsel[1]; // RULE9
		s_d.suppress = trig2; // RULE11
		s_d.adc = trig2 && adc_enable; // RULE10

		// Interrupt-only mode hands the pin back to the port data latch.
		if (mode1 == `MODE_SOFT_INT || mode1 == `MODE_OFF) begin
			s_d.pin1 = port_data_unit1; // RULE7
		end else if (pwm1_mode) begin
			s_d.pin1 = pwm1; // RULE13
		end else begin
			s_d.pin1 = latch1; // RULE2
		end
		if (mode2 == `MODE_SOFT_INT || mode2 == `MODE_OFF) begin
			s_d.pin2 = port_data_unit2; // RULE7
		end else begin
			s_d.pin2 = latch2; // RULE2
		end
		// The pin only drives once software has made it an output.
		s_d.oe1_n = port_c_direction_unit1; // RULE6
		s_d.oe2_n = port_c_direction_unit2; // RULE6
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.bus <= BUS_WAIT;
			s_q.cv1 <= `CV_RESET;
			s_q.cv2 <= `CV_RESET;
			s_q.ctrl1 <= `CTRL_RESET;
			s_q.ctrl2 <= `CTRL_RESET;
			s_q.tsel <= `SEL_RESET;
			s_q.oe1_n <= 1'b1;
			s_q.oe2_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.bus;
	assign unit1_output_pin = s_q.pin1;
	assign unit1_output_pin_oe_n = s_q.oe1_n;
	assign unit2_output_pin = s_q.pin2;
	assign unit2_output_pin_oe_n = s_q.oe2_n;
	assign unit1_match_flag = s_q.flag1;
	assign unit2_match_flag = s_q.flag2;
	assign timer_one_clear = s_q.t1_clear;
	assign timer_three_clear = s_q.t3_clear;
	assign timer_flag_suppress = s_q.suppress;
	assign adc_start = s_q.adc;

	a_flag_on_match: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		match1 |=> unit1_match_flag)
		else $error("Unit 1 flag not set after a match.");

	a_flag_stays_set: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		unit2_match_flag && !(flags_wr && wbyte[1]) |=> unit2_match_flag)
		else $error("Unit 2 flag dropped without a clear.");

	a_unit1_period: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
		trig1 |=> timer_one_clear ##1 !timer_one_clear || $past(trig1) || $past(trig2))
		else $error("Unit 1 trigger did not clear timer one.");

	a_unit2_timer: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE9
		trig2 |=> (timer_three_clear == $past(s_q.tsel[1])) && (timer_one_clear || timer_three_clear))
		else $error("Unit 2 trigger cleared the wrong timer.");

	a_adc_start: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE10
		trig2 |=> adc_start == $past(adc_enable))
		else $error("A/D start does not follow the unit 2 trigger.");

	a_timer_no_flag: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE11
		timer_three_clear |-> timer_flag_suppress)
		else $error("Timer three cleared without flag suppression.");

	a_bus_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("Bus answer not given after one wait cycle.");

	a_soft_int_pin: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
		mode1 == `MODE_SOFT_INT && !ctrl1_wr |=> unit1_output_pin == $past(port_data_unit1))
		else $error("Unit 1 pin driven by the unit in interrupt-only mode.");

	a_flag2_on_match: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		match2 |=> unit2_match_flag)
		else $error("Unit 2 flag not set after a match.");

	a_flag1_stays_set: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		unit1_match_flag && !(flags_wr && wbyte[`FLAG_UNIT1]) |=> unit1_match_flag)
		else $error("Unit 1 flag dropped without a clear.");

	a_flag1_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		flags_wr && wbyte[`FLAG_UNIT1] && !match1 |=> !unit1_match_flag)
		else $error("Unit 1 flag survived a clear.");

	a_flag2_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
		flags_wr && wbyte[`FLAG_UNIT2] && !match2 |=> !unit2_match_flag)
		else $error("Unit 2 flag survived a clear.");

	a_adc_single: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
		adc_start |=> !adc_start)
		else $error("A/D start pulse lasted more than one cycle.");

	a_suppress_single: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
		timer_flag_suppress |=> !timer_flag_suppress)
		else $error("Flag suppression pulse lasted more than one cycle.");

	a_pulses_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
		!trig1 && !trig2 |=> !timer_one_clear && !timer_three_clear && !adc_start)
		else $error("Trigger pulse seen without a trigger.");

	a_pin1_latch: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
		mode1 == `MODE_SET_HIGH |=> unit1_output_pin == $past(latch1))
		else $error("Unit 1 pin does not show its compare latch.");

	a_pin2_latch: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
		mode2 == `MODE_TOGGLE |=> unit2_output_pin == $past(latch2))
		else $error("Unit 2 pin does not show its compare latch.");

	a_soft_int_pin2: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
		mode2 == `MODE_SOFT_INT |=> unit2_output_pin == $past(port_data_unit2))
		else $error("Unit 2 pin driven by the unit in interrupt-only mode.");

	a_pwm_pin: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE13
		pwm1_mode |=> unit1_output_pin == $past(pwm1))
		else $error("Unit 1 pin does not show the PWM output.");

	a_oe1_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE6
		!port_c_direction_unit1 |=> !unit1_output_pin_oe_n)
		else $error("Unit 1 pin not driven although set as output.");

	a_oe2_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE6
		!port_c_direction_unit2 |=> !unit2_output_pin_oe_n)
		else $error("Unit 2 pin not driven although set as output.");

	a_zero_write_off: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
		ctrl1_wr && wbyte == 8'h00 |=> mode1 == `MODE_OFF)
		else $error("Zero control write did not disable unit 1.");

	a_select_commit: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE17
		wr_go && avs_address == `OFS_TIMER_SEL |=> s_q.tsel == $past(wbyte[1:0]))
		else $error("Timer select write did not land.");

	a_adc_cause: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE10
		adc_start |-> $past(adc_enable) && $past(trig2))
		else $error("A/D start without an enabled unit 2 trigger.");

	a_unit1_no_three: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
		trig1 && !trig2 |=> !timer_three_clear)
		else $error("Unit 1 trigger cleared timer three.");

	a_off_no_match: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
		mode1 == `MODE_OFF |-> !match1)
		else $error("Disabled unit 1 reported a match.");

endmodule // ccp_compare_top

// >>> verif/pin_load_model.sv
module pin_load_model (
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic drive_val,
	input  wire logic drive_oe_n,
	output logic      line_level,
	output int        rise_count
);
	timeunit 1ns;
	timeprecision 100ps;

	logic last_q;

	// A released pin goes to the board pull-up, so a stale driven value can never pass a check.
	assign line_level = drive_oe_n ? 1'h1 : drive_val;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_q     <= 1'h1;
			rise_count <= 0;
		end else begin
			last_q <= line_level;
			if (line_level && !last_q)
				rise_count <= rise_count + 1;
		end
	end
endmodule // pin_load_model

// >>> verif/ccp_compare_unit_tb_top.sv
`include "ccp_defines.svh"

module ccp_compare_unit_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk = 1'h0;
	logic        arst_n = 1'h0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [15:0] t1_cnt = 16'h0000;
	logic [15:0] t3_cnt = 16'h0000;
	logic [7:0]  t2_cnt = 8'h00;
	logic [1:0]  t2_fine = 2'h0;
	logic        t2_match = 1'h0;
	logic        adc_en = 1'h1;
	logic [1:0]  dir = 2'h3;
	logic [1:0]  pdata = 2'h0;
	logic [1:0]  pin, oe_n, flag, level;
	logic        t1_clr, t3_clr, sup, adc_go;
	int          rises [2];
	int          n_t1 = 0;
	int          n_t3 = 0;
	int          n_sup = 0;
	int          n_adc = 0;
	int          failures = 0;
	int          compares = 0;
	logic [31:0] rd;
	logic [3:0]  modes [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
	logic        pres [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
	logic        posts [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};

	always #12.5 core_clk = ~core_clk;

	ccp_compare_top ccp_compare_top_inst (
		.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer_one_count(t1_cnt),
		.timer_three_count(t3_cnt), .timer_two_count(t2_cnt), .timer_two_fine(t2_fine),
		.timer_two_period_match(t2_match), .adc_enable(adc_en),
		.port_c_direction_unit1(dir[0]), .port_c_direction_unit2(dir[1]),
		.port_data_unit1(pdata[0]), .port_data_unit2(pdata[1]),
		.unit1_output_pin(pin[0]), .unit1_output_pin_oe_n(oe_n[0]),
		.unit2_output_pin(pin[1]), .unit2_output_pin_oe_n(oe_n[1]),
		.unit1_match_flag(flag[0]), .unit2_match_flag(flag[1]),
		.timer_one_clear(t1_clr), .timer_three_clear(t3_clr),
		.timer_flag_suppress(sup), .adc_start(adc_go)
	);

	pin_load_model load1 (.core_clk(core_clk), .arst_n(arst_n), .drive_val(pin[0]),
		.drive_oe_n(oe_n[0]), .line_level(level[0]), .rise_count(rises[0]));
	pin_load_model load2 (.core_clk(core_clk), .arst_n(arst_n), .drive_val(pin[1]),
		.drive_oe_n(oe_n[1]), .line_level(level[1]), .rise_count(rises[1]));

	// Timers hold the counts the test sets and obey the clear pulses.
	always @(posedge core_clk) begin
		n_t1  <= n_t1 + int'(t1_clr);
		n_t3  <= n_t3 + int'(t3_clr);
		n_sup <= n_sup + int'(sup);
		n_adc <= n_adc + int'(adc_go);
		if (t1_clr)
			t1_cnt <= 16'h0000;
		if (t3_clr)
			t3_cnt <= 16'h0000;
	end

	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	// One access; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= {24'h000000, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		if (n >= 20)
			failures++;
		rd = avs_readdata;
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
		bus(1'h0, a, 8'h00);
		check(rd, exp, what);
	endtask

	task automatic run_mode(input int u, input logic [3:0] m, input logic three,
		input logic pre, input logic post);
		int         r0, c1, c3, cs, ca;
		logic       sp;
		logic [4:0] ctl;
		sp  = (m == `MODE_SPECIAL);
		ctl = u ? `OFS_UNIT2_CTRL : `OFS_UNIT1_CTRL;
		@(posedge core_clk);
		t1_cnt <= 16'h0000;
		t3_cnt <= 16'h0000;
		bus(1'h1, ctl, 8'h00);
		bus(1'h1, ctl, {4'h0, m});
		repeat (2) @(posedge core_clk);
		check(level[u], pre, "pin before match");
		check(flag[u], 1'h0, "flag before match");
		r0 = rises[u];
		c1 = n_t1;
		c3 = n_t3;
		cs = n_sup;
		ca = n_adc;
		if (three)
			t3_cnt <= 16'h1234;
		else
			t1_cnt <= 16'h1234;
		repeat (3) @(posedge core_clk);
		check(flag[u], 1'h1, "flag on match");
		check(level[u], post, "pin on match");
		repeat (6) @(posedge core_clk);
		check(level[u], post, "pin held");
		check(32'(rises[u] - r0), 32'(post && !pre), "pin rises");
		check(32'(n_t1 - c1), 32'(sp && !three), "timer one clears");
		check(32'(n_t3 - c3), 32'(sp && three), "timer three clears");
		check(32'(n_sup - cs), 32'(sp && u == 1), "flag suppress");
		check(32'(n_adc - ca), 32'(sp && u == 1 && adc_en), "adc start");
		bus(1'h1, `OFS_FLAGS, 8'h03);
		repeat (2) @(posedge core_clk);
		check(flag[u], 1'h0, "flag cleared, no rematch");
	endtask

	initial begin
		// The whole sequence needs about 330 cycles; reaching the 20000-cycle limit means a hang.
		#500000;
		failures++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'h1;
		dir    <= 2'h0;
		// Port data high makes interrupt-only mode distinguishable from the low latch.
		pdata  <= 2'h3;
		rd_chk(`OFS_UNIT1_CTRL, 32'h00000000, "ctrl1 reset");
		rd_chk(`OFS_UNIT2_CTRL, 32'h00000000, "ctrl2 reset");
		rd_chk(`OFS_FLAGS, 32'h00000000, "flags reset");
		rd_chk(`OFS_TIMER_SEL, 32'h00000000, "select reset");
		rd_chk(5'h1D, 32'h00000000, "unmapped");
		avs_byteenable <= 4'h0;
		bus(1'h1, `OFS_CV1_LOW, 8'h34);
		avs_byteenable <= 4'hF;
		rd_chk(`OFS_CV1_LOW, 32'h00000000, "byte lane off");
		bus(1'h1, `OFS_CV1_LOW, 8'h34);
		bus(1'h1, `OFS_CV1_HIGH, 8'h12);
		bus(1'h1, `OFS_CV2_LOW, 8'h34);
		bus(1'h1, `OFS_CV2_HIGH, 8'h12);
		rd_chk(`OFS_CV1_HIGH, 32'h00000012, "cv1 high");
		bus(1'h1, `OFS_TIMER_SEL, 8'h02);
		$display("test registers done");
		for (int u = 0; u < 2; u++)
			for (int k = 0; k < 5; k++)
				run_mode(u, modes[k], u == 1, pres[k], posts[k]);
		$display("test modes done");
		adc_en <= 1'h0;
		bus(1'h1, `OFS_TIMER_SEL, 8'h00);
		run_mode(1, `MODE_SPECIAL, 1'h0, 1'h0, 1'h0);
		$display("test trigger select done");
		bus(1'h1, `OFS_UNIT1_CTRL, {4'h0, `MODE_SET_LOW});
		rd_chk(`OFS_FLAGS, 32'h00000004, "latch high");
		bus(1'h1, `OFS_UNIT1_CTRL, 8'h00);
		rd_chk(`OFS_FLAGS, 32'h00000000, "latch cleared");
		t1_cnt <= 16'h1234;
		repeat (4) @(posedge core_clk);
		check(flag[0], 1'h0, "disabled no match");
		$display("test disable done");
		t1_cnt <= 16'h0000;
		bus(1'h1, `OFS_CV1_LOW, 8'h02);
		bus(1'h1, `OFS_UNIT1_CTRL, 8'h0C);
		@(posedge core_clk);
		t2_match <= 1'h1;
		@(posedge core_clk);
		t2_match <= 1'h0;
		repeat (3) @(posedge core_clk);
		check(level[0], 1'h1, "pwm high");
		t2_cnt <= 8'h02;
		repeat (3) @(posedge core_clk);
		check(level[0], 1'h0, "pwm low at duty");
		$display("test pwm done");
		complete_run();
	end
endmodule // ccp_compare_unit_tb_top
